// >>> hdl/afd_cfg.svh
// Opcode patterns, field codes and clock counts for the arithmetic/flag decoder.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef AFD_CFG_SVH
`define AFD_CFG_SVH

// ----------------------------------------
// Opcodes and patterns
// ----------------------------------------
`define AFD_OPC_AH_TO_FLAGS 8'h9e
`define AFD_OPC_FLAGS_TO_AH 8'h9f
`define AFD_MSK_ALU_RM 8'hc4
`define AFD_PAT_ALU_RM 8'h00
`define AFD_MSK_ALU_ACC 8'hc6
`define AFD_PAT_ALU_ACC 8'h04
`define AFD_MSK_IMM_GRP 8'hfc
`define AFD_PAT_IMM_GRP 8'h80

// ----------------------------------------
// Operation field codes
// ----------------------------------------
`define AFD_FLD_ADD 3'h0
`define AFD_FLD_ADC 3'h2
`define AFD_FLD_SUB_BORROW 3'h3
`define AFD_FLD_SUB 3'h5
`define AFD_MOD_REG 2'h3

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define AFD_BIT_W 0
`define AFD_BIT_D 1
`define AFD_BIT_S 1

// ----------------------------------------
// Clock counts
// ----------------------------------------
`define AFD_CNT_W 5
`define AFD_CLK_FLAGS 5'h02
`define AFD_CLK_RM_REG 5'h02
`define AFD_CLK_MEM 5'h07
`define AFD_CLK_IMM_REG 5'h03
`define AFD_CLK_ACC 5'h03

`endif

// >>> hdl/afd_pkg.sv
// Types shared by the arithmetic/flag decoder files.
// Assumes no surroundings beyond the compile order.
package afd_pkg;

    typedef enum logic [2:0] {
        AFD_OP_NONE,
        AFD_OP_ADD,
        AFD_OP_ADC,
        AFD_OP_SUB,
        AFD_OP_DIFFERENCE_WITH_BORROW,
        AFD_OP_AH_TO_FLAGS,
        AFD_OP_FLAGS_TO_AH
    } afd_op_t;

    typedef enum logic [1:0] {
        AFD_FORM_NONE,
        AFD_FORM_REGMEM,
        AFD_FORM_IMM_GRP,
        AFD_FORM_ACC_IMM
    } afd_form_t;

    typedef enum logic {
        AFD_ST_IDLE,
        AFD_ST_EXEC
    } afd_state_t;

endpackage

// >>> hdl/afd_decode.sv
// Combinational decode of one arithmetic or flag-copy instruction.
// Assumes all instruction bytes are presented together and held stable.
`timescale 1ns/1ps
`include "afd_cfg.svh"

module afd_decode
    import afd_pkg::*;
(
    input wire logic [7:0] opcode,
    input wire logic [7:0] modrm,
    input wire logic [7:0] imm_lo,
    input wire logic [7:0] imm_hi,
    output afd_op_t op,
    output afd_form_t form,
    output logic is_word,
    output logic dir_to_reg,
    output logic sign_ext,
    output logic [15:0] imm_value,
    output logic [`AFD_CNT_W-1:0] cycles
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] opc, input logic [7:0] pat, input logic [7:0] msk);
        return (opc & msk) == pat;
    endfunction

    function automatic afd_op_t kind_of(input logic [2:0] fld);
        afd_op_t k;
        k = AFD_OP_NONE;
        if (fld == `AFD_FLD_ADD)
            k = AFD_OP_ADD;
        else if (fld == `AFD_FLD_ADC)
            k = AFD_OP_ADC;
        else if (fld == `AFD_FLD_SUB)
            k = AFD_OP_SUB;
        else if (fld == `AFD_FLD_SUB_BORROW)
            k = AFD_OP_DIFFERENCE_WITH_BORROW;
        return k;
    endfunction

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic reg_operand;
    assign reg_operand = modrm[7:6] == `AFD_MOD_REG;

    always_comb
    begin
        op = AFD_OP_NONE;
        form = AFD_FORM_NONE;
        is_word = 1'b0;
        dir_to_reg = 1'b0;
        sign_ext = 1'b0;
        imm_value = 16'h0000;
        cycles = '0;
        if (opcode == `AFD_OPC_AH_TO_FLAGS)
        begin
            op = AFD_OP_AH_TO_FLAGS;
            cycles = `AFD_CLK_FLAGS;
        end
        else if (opcode == `AFD_OPC_FLAGS_TO_AH)
        begin
            op = AFD_OP_FLAGS_TO_AH;
            cycles = `AFD_CLK_FLAGS;
        end
        else if (hit(opcode, `AFD_PAT_ALU_RM, `AFD_MSK_ALU_RM) && kind_of(opcode[5:3]) != AFD_OP_NONE)
        begin
            // Register/memory form: 2 clocks with registers, 7 with memory
            op = kind_of(opcode[5:3]);
            form = AFD_FORM_REGMEM;
            is_word = opcode[`AFD_BIT_W];
            dir_to_reg = opcode[`AFD_BIT_D];
            cycles = reg_operand ? `AFD_CLK_RM_REG : `AFD_CLK_MEM;
        end
        else if (hit(opcode, `AFD_PAT_ALU_ACC, `AFD_MSK_ALU_ACC) && kind_of(opcode[5:3]) != AFD_OP_NONE)
        begin
            op = kind_of(opcode[5:3]);
            form = AFD_FORM_ACC_IMM;
            is_word = opcode[`AFD_BIT_W];
            imm_value = opcode[`AFD_BIT_W] ? {imm_hi, imm_lo} : {8'h00, imm_lo};
            cycles = `AFD_CLK_ACC;
        end
        else if (hit(opcode, `AFD_PAT_IMM_GRP, `AFD_MSK_IMM_GRP) && kind_of(modrm[5:3]) != AFD_OP_NONE)
        begin
            op = kind_of(modrm[5:3]);
            form = AFD_FORM_IMM_GRP;
            is_word = opcode[`AFD_BIT_W];
            sign_ext = opcode[`AFD_BIT_S] & opcode[`AFD_BIT_W];
            cycles = reg_operand ? `AFD_CLK_IMM_REG : `AFD_CLK_MEM;
            if (sign_ext)
                imm_value = {{8{imm_lo[7]}}, imm_lo};
            else if (opcode[`AFD_BIT_W])
                imm_value = {imm_hi, imm_lo};
            else
                imm_value = {8'h00, imm_lo};
        end
    end

endmodule // afd_decode

// >>> hdl/afd_core.sv
// Top of the arithmetic/flag decoder: accepts one instruction, decodes it
// and holds busy for the decoded clock count, then pulses done.
// Assumes instruction bytes synchronous to clk and valid with instr_valid.
//
// Contract
// - Opcode 9E copies AH to flags, 2 clocks
// - Add: rm, group field 000, accumulator forms
// - Subtract: rm, group field 101, accumulator forms
// - Add with carry: rm, field 010, accumulator
// - Subtract with borrow: rm, field 011, accumulator
// - Opcode 9F copies flags to AH, 2 clocks
`timescale 1ns/1ps
`include "afd_cfg.svh"

module afd_core
    import afd_pkg::*;
#(
    parameter int CNT_W = `AFD_CNT_W
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] modrm,
    input wire logic [7:0] imm_lo,
    input wire logic [7:0] imm_hi,
    output logic instr_ready,
    output logic busy,
    output logic done,
    output logic reject,
    output afd_op_t op_kind,
    output afd_form_t op_form,
    output logic is_word,
    output logic dir_to_reg,
    output logic sign_ext,
    output logic [15:0] imm_value,
    output logic [CNT_W-1:0] clock_count
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    generate
        if (CNT_W < 3)
        begin : g_bad_width
            $error("CNT_W too narrow for the longest clock count");
        end
    endgenerate

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        afd_state_t state;
        logic [CNT_W-1:0] remain;
        logic ready;
        logic busy;
        logic done;
        logic reject;
        afd_op_t op;
        afd_form_t form;
        logic word;
        logic dir;
        logic sext;
        logic [15:0] imm;
        logic [CNT_W-1:0] cycles;
    } afd_regs_t;

    afd_regs_t cur;
    afd_regs_t next_cur;

    afd_op_t dec_op;
    afd_form_t dec_form;
    logic dec_word;
    logic dec_dir;
    logic dec_sext;
    logic [15:0] dec_imm;
    logic [`AFD_CNT_W-1:0] dec_cycles;
    logic accept;

    afd_decode u_decode (
        .opcode(opcode),
        .modrm(modrm),
        .imm_lo(imm_lo),
        .imm_hi(imm_hi),
        .op(dec_op),
        .form(dec_form),
        .is_word(dec_word),
        .dir_to_reg(dec_dir),
        .sign_ext(dec_sext),
        .imm_value(dec_imm),
        .cycles(dec_cycles)
    );

    assign accept = instr_valid && cur.ready;

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_comb
    begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.reject = 1'b0;
        case (cur.state)
            AFD_ST_IDLE:
            begin
                if (accept)
                begin
                    next_cur.op = dec_op;
                    next_cur.form = dec_form;
                    next_cur.word = dec_word;
                    next_cur.dir = dec_dir;
                    next_cur.sext = dec_sext;
                    next_cur.imm = dec_imm;
                    next_cur.cycles = CNT_W'(dec_cycles);
                    if (dec_op == AFD_OP_NONE)
                        next_cur.reject = 1'b1;
                    else
                    begin
                        // Busy stands exactly the decoded clock count
                        next_cur.state = AFD_ST_EXEC;
                        next_cur.ready = 1'b0;
                        next_cur.busy = 1'b1;
                        next_cur.remain = CNT_W'(dec_cycles - 1'b1);
                    end
                end
            end
            AFD_ST_EXEC:
            begin
                if (cur.remain == '0)
                begin
                    next_cur.state = AFD_ST_IDLE;
                    next_cur.busy = 1'b0;
                    next_cur.ready = 1'b1;
                    next_cur.done = 1'b1;
                end
                else
                    next_cur.remain = cur.remain - 1'b1;
            end
            default:
                next_cur.state = AFD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur <= '0;
            cur.state <= AFD_ST_IDLE;
            cur.ready <= 1'b1;
        end
        else
            cur <= next_cur;
    end

    assign instr_ready = cur.ready;
    assign busy = cur.busy;
    assign done = cur.done;
    assign reject = cur.reject;
    assign op_kind = cur.op;
    assign op_form = cur.form;
    assign is_word = cur.word;
    assign dir_to_reg = cur.dir;
    assign sign_ext = cur.sext;
    assign imm_value = cur.imm;
    assign clock_count = cur.cycles;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_ah_flags_time: assert property (
        accept && opcode == `AFD_OPC_AH_TO_FLAGS |=> op_kind == AFD_OP_AH_TO_FLAGS && busy[*2] ##1 !busy && done)
        else $error("flag load from AH not decoded or not 2 clocks");

    a_add_acc_form: assert property (
        accept && opcode[7:1] == 7'h02 |=> op_kind == AFD_OP_ADD && op_form == AFD_FORM_ACC_IMM
        && busy[*3] ##1 done)
        else $error("add accumulator form wrong or not 3 clocks");

    a_sub_mem_time: assert property (
        accept && opcode[7:2] == 6'h0a && modrm[7:6] != `AFD_MOD_REG
        |=> op_kind == AFD_OP_SUB && clock_count == `AFD_CLK_MEM ##6 busy ##1 done)
        else $error("subtract memory form not 7 clocks");

    a_adc_imm_reg: assert property (
        accept && opcode[7:2] == 6'h20 && modrm[5:3] == `AFD_FLD_ADC && modrm[7:6] == `AFD_MOD_REG
        |=> op_kind == AFD_OP_ADC && op_form == AFD_FORM_IMM_GRP && clock_count == `AFD_CLK_IMM_REG)
        else $error("add with carry immediate form wrong");

    a_sbb_acc_form: assert property (
        accept && opcode[7:1] == 7'h0e |=> op_kind == AFD_OP_DIFFERENCE_WITH_BORROW
        && op_form == AFD_FORM_ACC_IMM && is_word == $past(opcode[0]))
        else $error("borrow subtract accumulator form wrong");

    a_sign_extend: assert property (
        !busy ##1 busy && sign_ext |-> is_word && op_form == AFD_FORM_IMM_GRP
        && imm_value[15:8] == {8{imm_value[7]}})
        else $error("sign-extended immediate not extended");

    a_flags_ah_time: assert property (
        accept && opcode == `AFD_OPC_FLAGS_TO_AH |=> op_kind == AFD_OP_FLAGS_TO_AH
        && !instr_ready ##1 busy ##1 done && instr_ready)
        else $error("flag copy to AH not decoded or not 2 clocks");

    a_rm_reg_time: assert property (
        accept && opcode[7:2] == 6'h00 && modrm[7:6] == `AFD_MOD_REG |=> op_kind == AFD_OP_ADD
        && op_form == AFD_FORM_REGMEM && busy[*2] ##1 done)
        else $error("add register form wrong or not 2 clocks");

    a_busy_refuses: assert property (
        busy |-> !instr_ready && !done && !reject)
        else $error("request window open while busy");

    c_add_mem: cover property (accept && opcode[7:2] == 6'h00 && modrm[7:6] != `AFD_MOD_REG ##1 busy[*7] ##1 done);
    c_flag_copy: cover property (accept && opcode == `AFD_OPC_AH_TO_FLAGS ##3 accept && opcode == `AFD_OPC_FLAGS_TO_AH);
    c_sext_imm: cover property (accept && opcode == 8'h83 && modrm[5:3] == `AFD_FLD_SUB_BORROW);
    c_reject: cover property (reject);

endmodule // afd_core

// >>> dv/tb_top.sv
// Self-checking bench for the arithmetic/flag decoder top, afd_core.
// Assumes afd_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module tb_top
    import afd_pkg::*;
;
    typedef struct packed {
        afd_op_t op;
        afd_form_t form;
        logic w;
        logic d;
        logic s;
        logic [15:0] imm;
        logic [4:0] cnt;
    } afd_exp_t;

    logic clk, sys_rst, instr_valid;
    logic [7:0] opcode, modrm, imm_lo, imm_hi;
    logic instr_ready, busy, done, reject, is_word, dir_to_reg, sign_ext;
    afd_op_t op_kind;
    afd_form_t op_form;
    logic [15:0] imm_value;
    logic [4:0] clock_count;
    logic [31:0] seed;
    int errors, compares;
    logic [7:0] rmb [4] = '{8'h00, 8'h10, 8'h28, 8'h18};
    logic [7:0] accb [4] = '{8'h04, 8'h14, 8'h2c, 8'h1c};
    logic [2:0] fld [4] = '{3'h0, 3'h2, 3'h5, 3'h3};
    logic [7:0] bad [9] = '{8'h08, 8'h06, 8'h0f, 8'h9c, 8'hfe, 8'h38, 8'h20, 8'h9d, 8'h3c};

    afd_core #(.CNT_W(5)) DUT (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .opcode(opcode),
        .modrm(modrm), .imm_lo(imm_lo), .imm_hi(imm_hi), .instr_ready(instr_ready), .busy(busy), .done(done),
        .reject(reject), .op_kind(op_kind), .op_form(op_form), .is_word(is_word), .dir_to_reg(dir_to_reg),
        .sign_ext(sign_ext), .imm_value(imm_value), .clock_count(clock_count));

    always #4 clk = ~clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic afd_op_t op_of(input logic [2:0] f);
        case (f)
            3'h0: return AFD_OP_ADD;
            3'h2: return AFD_OP_ADC;
            3'h3: return AFD_OP_DIFFERENCE_WITH_BORROW;
            3'h5: return AFD_OP_SUB;
            default: return AFD_OP_NONE;
        endcase
    endfunction

    function automatic afd_exp_t expect_of(input logic [7:0] oc, m, lo, hi);
        afd_exp_t e;
        logic rg;
        e = '0;
        rg = (m[7:6] == 2'h3);
        if (oc == 8'h9e || oc == 8'h9f)
        begin
            e.op = (oc[0]) ? AFD_OP_FLAGS_TO_AH : AFD_OP_AH_TO_FLAGS;
            e.cnt = 5'h02;
        end
        else if (oc[7:6] == 2'h0 && !oc[2] && op_of(oc[5:3]) != AFD_OP_NONE)
        begin
            e = '{op_of(oc[5:3]), AFD_FORM_REGMEM, oc[0], oc[1], 1'b0, 16'h0000, rg ? 5'h02 : 5'h07};
        end
        else if (oc[7:6] == 2'h0 && oc[2:1] == 2'h2 && op_of(oc[5:3]) != AFD_OP_NONE)
        begin
            e = '{op_of(oc[5:3]), AFD_FORM_ACC_IMM, oc[0], 1'b0, 1'b0, {oc[0] ? hi : 8'h00, lo}, 5'h03};
        end
        else if (oc[7:2] == 6'h20 && op_of(m[5:3]) != AFD_OP_NONE)
        begin
            e = '{op_of(m[5:3]), AFD_FORM_IMM_GRP, oc[0], 1'b0, oc[1] & oc[0], 16'h0000, rg ? 5'h03 : 5'h07};
            e.imm = e.s ? {{8{lo[7]}}, lo} : {oc[0] ? hi : 8'h00, lo};
        end
        return e;
    endfunction

    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (exp !== got)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rst_chk();
        chk("reset_state", 40'h01_0000_0000, {instr_ready, busy, done, reject, op_kind, op_form, is_word,
            dir_to_reg, sign_ext, imm_value, clock_count});
    endtask

    // Drives one instruction, pokes refused requests while busy
    task automatic issue(input logic [7:0] oc, m, lo, hi);
        afd_exp_t e;
        int n;
        e = expect_of(oc, m, lo, hi);
        n = e.cnt;
        @(posedge clk);
        instr_valid <= 1'b1;
        opcode <= oc;
        modrm <= m;
        imm_lo <= lo;
        imm_hi <= hi;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk("reject", e.op == AFD_OP_NONE, reject);
        if (e.op == AFD_OP_NONE)
        begin
            chk("rejected_op", {busy, instr_ready, op_kind}, {1'b0, 1'b1, AFD_OP_NONE});
            return;
        end
        chk("decode", e, {op_kind, op_form, is_word, dir_to_reg, sign_ext, imm_value, clock_count});
        for (int i = 0; i <= n; i++)
        begin
            if (i > 0)
            begin
                @(posedge clk);
                instr_valid <= (i < n - 1) ? rnd() >> 31 : 1'b0;
                opcode <= rnd();
            end
            #1;
            chk("busy_done_ready", {i < n, i == n, i == n}, {busy, done, instr_ready});
            chk("op_hold", e.op, op_kind);
        end
    endtask

    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] r;
        clk = 0;
        sys_rst = 1;
        instr_valid = 0;
        {opcode, modrm, imm_lo, imm_hi} = '0;
        seed = 32'h0000_ac7a;
        errors = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        #1;
        rst_chk();
        @(posedge clk);
        sys_rst <= 1'b0;
        issue(8'h9e, 8'h00, 8'h00, 8'h00);
        issue(8'h9f, 8'hff, 8'hff, 8'hff);
        for (int k = 0; k < 4; k++)
            for (int j = 0; j < 4; j++)
            begin
                issue(rmb[k] | 8'(j), j[0] ? 8'hc1 : 8'h46, 8'h5a, 8'ha5);
                issue(8'h80 | 8'(j), {j[1] ? 2'h3 : 2'h1, fld[k], 3'h2}, 8'h9c, 8'h3e);
                issue(accb[k] | 8'(j[0]), 8'h00, 8'h9c, 8'h3e);
            end
        issue(8'h83, 8'hc3, 8'h80, 8'h12);
        issue(8'h83, 8'h03, 8'h7f, 8'hee);
        issue(8'h82, 8'hc3, 8'h80, 8'h12);
        for (int k = 0; k < 9; k++)
            issue(bad[k], {2'h3, k[2:0] | 3'h1, 3'h0}, 8'h11, 8'h22);
        issue(8'h83, 8'hf8, 8'h01, 8'h02);
        repeat (200)
        begin
            r = rnd();
            case (r[1:0])
                2'h0: issue(r[15:8], rnd(), rnd(), rnd());
                2'h1: issue(8'h80 | 8'(r[9:8]), rnd(), rnd(), rnd());
                2'h2: issue(rmb[r[9:8]] | 8'(r[11:10]), rnd(), rnd(), rnd());
                default: issue(accb[r[9:8]] | 8'(r[10]), rnd(), rnd(), rnd());
            endcase
        end
        // Refused opcode, then back to back; held flag copy taken in done cycle
        @(posedge clk);
        instr_valid <= 1'b1;
        opcode <= 8'h38;
        @(posedge clk);
        opcode <= 8'h9e;
        #1;
        chk("b2b_reject", 2'b11, {reject, instr_ready});
        @(posedge clk);
        opcode <= 8'h9f;
        #1;
        chk("b2b_ah_to_flags", {AFD_OP_AH_TO_FLAGS, 1'b1}, {op_kind, busy});
        repeat (2) @(posedge clk);
        #1;
        chk("b2b_done", 2'b11, {done, instr_ready});
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk("b2b_flags_to_ah", {AFD_OP_FLAGS_TO_AH, 1'b1}, {op_kind, busy});
        repeat (2) @(posedge clk);
        @(posedge clk);
        instr_valid <= 1'b1;
        opcode <= 8'h03;
        modrm <= 8'h06;
        @(posedge clk);
        instr_valid <= 1'b0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b1;
        #1;
        rst_chk();
        @(posedge clk);
        sys_rst <= 1'b0;
        issue(8'h2d, 8'h00, 8'h34, 8'h12);
        summarize();
    end

    initial
    begin
        #200_000;
        errors++;
        summarize();
    end
endmodule // tb_top
